// File: dv/serial_peer_model.sv
// peripheral on the far side of the three-wire link, one byte per frame
`timescale 1ns/1ps

module serial_peer_model (
  input  wire logic       sck_i,
  input  wire logic       so_i,
  input  wire logic       lsb_first_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            si_o,
  output logic [7:0]      rx_byte_o,
  output logic            ext_sck_o
);
  logic [2:0] bit_idx;

  initial begin
    si_o      = 1'b0;
    rx_byte_o = 8'h00;
    ext_sck_o = 1'b1;
    bit_idx   = 3'd0;
    // the line settling from unknown at time zero looks like a rise; forget it
    #1;
    bit_idx   = 3'd0;
  end

  // next bit leaves on the fall, so it is settled long before the device samples
  always @(negedge sck_i) begin
    si_o <= lsb_first_i ? tx_byte_i[bit_idx] : tx_byte_i[3'd7 - bit_idx];
  end

  // capture on the rise; the wrapping count frames eight bits
  always @(posedge sck_i) begin
    rx_byte_o <= lsb_first_i ? {so_i, rx_byte_o[6'd7:1]} : {rx_byte_o[6:0], so_i};
    bit_idx   <= bit_idx + 3'd1;
  end

  // external clock idles high, runs one frame, edges kept off the system clock
  task automatic clock_byte(input int half_ns);
    #3;
    repeat (16) #(half_ns) ext_sck_o = ~ext_sck_o;
  endtask
endmodule

// File: dv/three_wire_serial_io_mode_tb.sv
// self-checking bench: registers, internal and external clock transfers, abort
`timescale 1ns/1ps
`include "three_wire_sio_defines.svh"

module three_wire_serial_io_mode_tb;
  logic        clk_sys_i, rst_n_i, hsel, hwrite, hready, hresp;
  logic        sck_o, sck_oe, ext_sck, sck_line, so, si, irq, lsb_first;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  peer_tx, peer_rx;
  int          num_errors, comparisons, irq_count;

  // pin level: device drives it when enabled, otherwise the peer's clock
  assign sck_line = (sck_oe === 1'b1) ? sck_o : ext_sck;

  three_wire_serial_io_mode three_wire_serial_io_mode_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .serial_clock_pin_i(sck_line), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_o(sck_oe), .serial_out_pin_o(so), .serial_in_pin_i(si), .transfer_done_irq_o(irq));

  serial_peer_model serial_peer_model_i (
    .sck_i(sck_line), .so_i(so), .lsb_first_i(lsb_first), .tx_byte_i(peer_tx),
    .si_o(si), .rx_byte_o(peer_rx), .ext_sck_o(ext_sck));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // every done pulse is counted; one per byte is expected
  always @(posedge clk_sys_i) if (irq === 1'b1) irq_count <= irq_count + 1;

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one ahb single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {14'h0000, idx, 2'b00};
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp, input string name);
    bus(1'b0, idx, 8'h00);
    check(name, rd, {24'h00_0000, exp});
  endtask

  // mode first, then data, so the enable is already set at the data write
  task automatic xfer(input logic [7:0] mode, input logic [7:0] dtx, input logic [7:0] ptx);
    peer_tx   <= ptx;
    lsb_first <= mode[2];
    bus(1'b1, `SYNC_SERIAL_MODE_IDX, mode);
    bus(1'b1, `SHIFT_DATA_IDX, dtx);
  endtask

  task automatic finish_xfer(input logic [7:0] dtx, input logic [7:0] ptx, input int limit);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < limit) begin
      @(posedge clk_sys_i);
      n++;
    end
    check("done", {31'h0, irq}, 32'h1);
    bus(1'b0, `SHIFT_DATA_IDX, 8'h00);
    check("rx byte", rd, {24'h00_0000, ptx});
    check("peer byte", {24'h00_0000, peer_rx}, {24'h00_0000, dtx});
    check("out held", {31'h0, so}, {31'h0, lsb_first ? dtx[7] : dtx[0]});
  endtask

  // watchdog well past the expected run of about thirteen thousand cycles
  initial begin
    #600_000;
    num_errors++;
    $display("BAD watchdog expected finish seen timeout");
    report_and_stop();
  end

  initial begin
    rst_n_i = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    peer_tx = 8'h00;
    lsb_first = 1'b0;
    num_errors = 0;
    comparisons = 0;
    irq_count = 0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd_chk(`ASYNC_FRAME_CONFIG_IDX, 8'h00, "async reset");
    rd_chk(`SYNC_SERIAL_MODE_IDX, 8'h00, "mode reset");
    rd_chk(`BAUD_DIVIDER_SELECT_IDX, 8'h00, "baud reset");
    bus(1'b1, 16'hff71, 8'hff);
    rd_chk(16'hff71, 8'h00, "unmapped");
    bus(1'b1, `ASYNC_FRAME_CONFIG_IDX, 8'hff);
    rd_chk(`ASYNC_FRAME_CONFIG_IDX, 8'hfc, "async fields");
    bus(1'b1, `ASYNC_FRAME_CONFIG_IDX, 8'h00);
    bus(1'b1, `BAUD_DIVIDER_SELECT_IDX, 8'hff);
    rd_chk(`BAUD_DIVIDER_SELECT_IDX, 8'h0f, "baud field");
    // data written while disabled must stay put after enabling
    bus(1'b1, `SYNC_SERIAL_MODE_IDX, 8'h02);
    bus(1'b1, `SHIFT_DATA_IDX, 8'h5a);
    bus(1'b1, `SYNC_SERIAL_MODE_IDX, 8'h82);
    repeat (600) @(posedge clk_sys_i);
    check("no start", irq_count, 0);
    rd_chk(`SERIAL_STATUS_IDX, 8'h02, "still idle");
    // every legal divider code 0 to 7, order alternating; then code 9, which runs as code 7
    for (int c = 0; c < 9; c++) begin
      bus(1'b1, `BAUD_DIVIDER_SELECT_IDX, (c == 8) ? 8'h09 : c[7:0]);
      xfer(c[0] ? 8'h86 : 8'h82, 8'ha5 ^ c[7:0], 8'h3c + c[7:0]);
      if (c == 1) bus(1'b1, `SHIFT_DATA_IDX, 8'hff);
      finish_xfer(8'ha5 ^ c[7:0], 8'h3c + c[7:0], 5000);
    end
    // external clock from the peer, pin made an input
    bus(1'b1, `PORT_DIRECTION_IDX, 8'h01);
    xfer(8'h80, 8'hc3, 8'h96);
    serial_peer_model_i.clock_byte(40);
    finish_xfer(8'hc3, 8'h96, 100);
    check("one done each", irq_count, 10);
    // disable in mid-byte: no done, clock back high
    bus(1'b1, `PORT_DIRECTION_IDX, 8'h00);
    bus(1'b1, `BAUD_DIVIDER_SELECT_IDX, 8'h02);
    xfer(8'h82, 8'h11, 8'h22);
    repeat (40) @(posedge clk_sys_i);
    bus(1'b1, `SYNC_SERIAL_MODE_IDX, 8'h00);
    repeat (200) @(posedge clk_sys_i);
    check("abort quiet", irq_count, 10);
    rd_chk(`SERIAL_STATUS_IDX, 8'h02, "abort idle");
    report_and_stop();
  end
endmodule

// File: dv/three_wire_sio_chk.sv
// port checker for the three-wire serial block, bound into the design
`timescale 1ns/1ps
`include "three_wire_sio_defines.svh"

module three_wire_sio_chk (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic        serial_clock_pin_i,
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe_o,
  input wire logic        serial_out_pin_o,
  input wire logic        transfer_done_irq_o
);
  logic        wr_pend, pdir, sck_q, int_clk, line, irq_q;
  logic [15:0] wr_idx;
  logic [7:0]  mode;
  logic [3:0]  code, rises;
  logic [9:0]  low_cnt, half;

  // clock line in use, and the expected half period
  assign int_clk = mode[7] & mode[1];
  assign line    = int_clk ? serial_clock_pin_o : serial_clock_pin_i;
  assign half    = (code > `SRC_CLK_SEL_MAX) ? 10'h100 : (10'h002 << code); // prohibited codes run as the slowest

  // shadow of the control registers, rebuilt from ahb write data phases
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      wr_idx  <= 16'h0000;
      mode    <= 8'h00;
      pdir    <= 1'b0;
      code    <= 4'h0;
    end else begin
      wr_pend <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
      wr_idx  <= haddr_i[17:2];
      if (wr_pend && wr_idx == `SYNC_SERIAL_MODE_IDX) mode <= hwdata_i[7:0] & `SYNC_SERIAL_MODE_MASK;
      if (wr_pend && wr_idx == `PORT_DIRECTION_IDX) pdir <= hwdata_i[0];
      if (wr_pend && wr_idx == `BAUD_DIVIDER_SELECT_IDX) code <= hwdata_i[3:0];
    end
  end

  // low time of the generated clock and rises seen within the current byte;
  // cleared a cycle after the done pulse, since a driven clock rise is seen one cycle late
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sck_q   <= 1'b1;
      irq_q   <= 1'b0;
      low_cnt <= 10'h000;
      rises   <= 4'h0;
    end else begin
      sck_q   <= line;
      irq_q   <= transfer_done_irq_o;
      low_cnt <= serial_clock_pin_o ? 10'h000 : low_cnt + 10'h001;
      if (!mode[7] || irq_q) rises <= 4'h0;
      else if (line && !sck_q) rises <= rises + 4'h1;
    end
  end

  default clocking main_cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  drive_enable_a: assert property (serial_clock_pin_oe_o == (int_clk && !pdir))
    else $error("clock pin drive enable wrong");
  idle_high_a: assert property (!mode[7] ##1 !mode[7] |-> serial_clock_pin_o)
    else $error("clock not high while disabled");
  half_period_a: assert property (int_clk && $rose(serial_clock_pin_o) |-> low_cnt == half)
    else $error("clock half period wrong");
  irq_cause_a: assert property (transfer_done_irq_o |=> rises == 4'h8)
    else $error("done without eight clock rises");
  irq_bound_a: assert property (rises == 4'h7 && line && !sck_q |-> ##[0:2] transfer_done_irq_o)
    else $error("done missing after eighth rise");
  irq_pulse_a: assert property (transfer_done_irq_o |=> !transfer_done_irq_o)
    else $error("done longer than one cycle");
  no_ninth_a: assert property (rises <= 4'h8)
    else $error("clock ran past eight bits");
  out_hold_a: assert property (int_clk && $changed(serial_out_pin_o) |-> !serial_clock_pin_o || !$past(serial_clock_pin_o))
    else $error("serial out moved away from a fall");

  cover property (int_clk && transfer_done_irq_o);
  cover property (!int_clk && transfer_done_irq_o);
  cover property ($fell(mode[7]) && rises != 4'h0);
endmodule

bind three_wire_serial_io_mode three_wire_sio_chk three_wire_sio_chk_i (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .serial_clock_pin_i(serial_clock_pin_i), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe_o(serial_clock_pin_oe_o), .serial_out_pin_o(serial_out_pin_o),
  .transfer_done_irq_o(transfer_done_irq_o));

// File: logic/serial_clock_divider.sv
// baud rate generator: half-period ticks of the internal serial clock
`timescale 1ns/1ps
`include "three_wire_sio_defines.svh"

module serial_clock_divider (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [3:0] src_clk_sel_i,
  output logic            half_tick_o
);

  logic [`DIV_COUNT_W-1:0] count;
  logic [`DIV_COUNT_W-1:0] half_last;
  logic [3:0]              sel_eff;

  // half period is 2^n cycles with n = code + 1, so the full period is 2^(n+1)
  function automatic logic [`DIV_COUNT_W-1:0] half_period_last(input logic [3:0] code);
    logic [`DIV_COUNT_W-1:0] one;
    one = {{(`DIV_COUNT_W-1){1'b0}}, 1'b1};
    half_period_last = (one << (code + 4'h1)) - one;
  endfunction

  // prohibited codes are clamped to the slowest legal rate rather than left undefined
  assign sel_eff   = (src_clk_sel_i > `SRC_CLK_SEL_MAX) ? `SRC_CLK_SEL_MAX : src_clk_sel_i; // see [R10]
  assign half_last = half_period_last(sel_eff); // see [R11]

  // counter restarts whenever the generator is stopped so each frame starts clean
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !run_i) begin
      count       <= '0;
      half_tick_o <= 1'b0;
    end else if (count == half_last) begin
      count       <= '0;
      half_tick_o <= 1'b1;
    end else begin
      count       <= count + {{(`DIV_COUNT_W-1){1'b0}}, 1'b1};
      half_tick_o <= 1'b0;
    end
  end

endmodule

// File: logic/three_wire_serial_io_mode.sv
// three-wire clocked serial i/o block with its ahb-lite register slave
`timescale 1ns/1ps
`include "three_wire_sio_defines.svh"

// Functional notes
// [R1] reset clears sync mode, async config and baud divider registers to zero
// [R2] enable bit 7 of sync mode: 0 disables, 1 enables three-wire operation
// [R3] clock source bit: 0 external clock pin, 1 internal baud generator
// [R4] bit 2 of sync mode: 0 shifts MSB first, 1 shifts LSB first
// [R5] software writes zero to sync mode bits 0 and 3 to 6
// [R6] software halts any transfer before changing the operating mode
// [R7] software keeps async config at zero while three-wire mode runs
// [R8] async config: tx enable bit 7, rx enable bit 6, two-bit parity field
// [R9] async config: char length and stop length bits; bits 0 and 1 zero
// [R10] divider codes 0 to 7 select main clock over 2^n, n 1 to 8
// [R11] internal serial clock frequency is main clock over 2^(n+1)
// [R12] software never writes the baud divider during a transfer
// [R13] external clock needs no divider; software sets port direction bit 0
// [R14] each transfer moves exactly eight bits, full duplex, one per clock period
// [R15] shift registers move on falling clock edge; output latch drives serial out; here rx_shift_reg shifts on the rising edge instead
// [R16] serial input is captured on each rising clock edge
// [R17] after the eighth bit shifting stops and the done request is raised
// [R18] tx write starts only if enabled and clock idle or high after previous byte
// [R19] setting enable after writing tx data does not start a transfer
// [R20] between transfers serial out keeps the last bit shifted out
// [R21] done request is one system-clock pulse with receive buffer already valid
module three_wire_serial_io_mode (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // serial clock pin, split into its three signals
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_o,
  // serial data pins
  output logic             serial_out_pin_o,
  input  wire logic        serial_in_pin_i,
  // transfer complete request
  output logic             transfer_done_irq_o
);

  // register state
  logic [7:0] sync_serial_mode;
  logic [7:0] async_frame_config;
  logic [7:0] baud_divider_select;
  logic [7:0] port_direction_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_buffer_reg;

  // bus capture
  logic        wr_pending;
  logic [15:0] wr_index;
  logic        addr_phase;
  logic [15:0] addr_index;
  logic        wr_valid;

  // transfer engine
  three_wire_sio_pkg::xfer_state_t state;
  logic [3:0] bit_count;
  logic       sck_out;
  logic       sck_prev;
  logic       ext_fall;
  logic       ext_rise;
  logic       int_tick;
  logic       int_fall;
  logic       int_rise;
  logic       do_fall;
  logic       do_rise;
  logic       last_rise;
  logic       tx_write;
  logic       start_ok;
  logic       start_xfer;

  // decoded controls
  logic       op_enable;
  logic       clk_internal;
  logic       lsb_first;

  assign op_enable    = sync_serial_mode[`SERIAL_OP_ENABLE_BIT];    // see [R2]
  assign clk_internal = sync_serial_mode[`SERIAL_CLOCK_SOURCE_BIT]; // see [R3]
  assign lsb_first    = sync_serial_mode[`FIRST_BIT_SELECT_BIT];    // see [R4]

  // ------------------------------------------------------------------
  // ahb-lite slave: zero wait states, always OKAY
  // ------------------------------------------------------------------

  // byte address is four times the register index; low two bits ignored
  function automatic logic [15:0] word_index(input logic [31:0] addr);
    word_index = addr[17:2];
  endfunction

  assign addr_phase  = hsel_i && hready_i && htrans_i[`HTRANS_NONSEQ_BIT];
  assign addr_index  = word_index(haddr_i);
  assign hreadyout_o = 1'b1;
  assign hresp_o     = `HRESP_OKAY;
  assign wr_valid    = wr_pending;

  // remember a write address phase so the data phase knows its target
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_pending <= 1'b0;
      wr_index   <= 16'h0000;
    end else begin
      wr_pending <= addr_phase && hwrite_i;
      wr_index   <= addr_index;
    end
  end

  // read data is latched at the address phase; a read right behind a write
  // to the same register returns the value from before that write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_phase && !hwrite_i) begin
      unique case (addr_index)
        `ASYNC_FRAME_CONFIG_IDX:  hrdata_o <= {24'h00_0000, async_frame_config};
        `SYNC_SERIAL_MODE_IDX:    hrdata_o <= {24'h00_0000, sync_serial_mode};
        `BAUD_DIVIDER_SELECT_IDX: hrdata_o <= {24'h00_0000, baud_divider_select};
        `SHIFT_DATA_IDX:          hrdata_o <= {24'h00_0000, rx_buffer_reg};
        `SERIAL_STATUS_IDX:       hrdata_o <= {30'h0000_0000, sck_out, (state == three_wire_sio_pkg::ST_SHIFT)};
        `PORT_DIRECTION_IDX:      hrdata_o <= {24'h00_0000, port_direction_reg};
        default:                  hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------

  // reserved bits are masked so they read back zero whatever software writes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sync_serial_mode <= `SYNC_SERIAL_MODE_RST; // see [R1]
    end else if (wr_valid && wr_index == `SYNC_SERIAL_MODE_IDX) begin
      sync_serial_mode <= hwdata_i[7:0] & `SYNC_SERIAL_MODE_MASK; // see [R5]
    end
  end

  // frame format of the async mode; stored only, unused while three-wire runs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      async_frame_config <= `ASYNC_FRAME_CONFIG_RST; // see [R1]
    end else if (wr_valid && wr_index == `ASYNC_FRAME_CONFIG_IDX) begin
      async_frame_config <= hwdata_i[7:0] & `ASYNC_FRAME_CONFIG_MASK; // see [R8] see [R9]
    end
  end

  // divider code; a write mid-transfer takes effect at once and upsets timing
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      baud_divider_select <= `BAUD_DIVIDER_SELECT_RST; // see [R1]
    end else if (wr_valid && wr_index == `BAUD_DIVIDER_SELECT_IDX) begin
      baud_divider_select <= hwdata_i[7:0] & `BAUD_DIVIDER_SELECT_MASK; // see [R10]
    end
  end

  // clock pin direction; bit 0 high releases the pin for an external clock
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      port_direction_reg <= `PORT_DIRECTION_RST;
    end else if (wr_valid && wr_index == `PORT_DIRECTION_IDX) begin
      port_direction_reg <= hwdata_i[7:0] & `PORT_DIRECTION_MASK; // see [R13]
    end
  end

  // ------------------------------------------------------------------
  // serial clock sources
  // ------------------------------------------------------------------

  // internal generator runs only while a transfer is under way
  serial_clock_divider u_divider (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .run_i         (state == three_wire_sio_pkg::ST_SHIFT && clk_internal),
    .src_clk_sel_i (baud_divider_select[3:0]),
    .half_tick_o   (int_tick)
  );

  // pin level one cycle back, for edge detection of the external clock
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sck_prev <= 1'b1;
    end else begin
      sck_prev <= serial_clock_pin_i;
    end
  end

  assign ext_fall = sck_prev && !serial_clock_pin_i;
  assign ext_rise = !sck_prev && serial_clock_pin_i;
  assign int_fall = int_tick && sck_out;
  assign int_rise = int_tick && !sck_out;

  // only the selected source moves the shifter, and only during a transfer
  assign do_fall   = (state == three_wire_sio_pkg::ST_SHIFT) &&
                     (clk_internal ? int_fall : ext_fall); // see [R15]
  assign do_rise   = (state == three_wire_sio_pkg::ST_SHIFT) &&
                     (clk_internal ? int_rise : ext_rise); // see [R16]
  assign last_rise = do_rise && (bit_count == `BITS_PER_TRANSFER - 4'h1); // see [R14]

  // internal clock output idles high; drives the pin only when it is master
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !op_enable) begin
      sck_out <= 1'b1;
    end else if (state == three_wire_sio_pkg::ST_IDLE) begin
      sck_out <= 1'b1;
    end else if (clk_internal && int_tick) begin
      sck_out <= !sck_out;
    end
  end

  assign serial_clock_pin_o    = sck_out;
  assign serial_clock_pin_oe_o = op_enable && clk_internal &&
                                 !port_direction_reg[`CLOCK_PIN_INPUT_BIT];

  // ------------------------------------------------------------------
  // transfer start and sequencing
  // ------------------------------------------------------------------

  assign tx_write = wr_valid && wr_index == `SHIFT_DATA_IDX;

  // start is judged at the write itself; a later enable never starts it
  assign start_ok   = op_enable && (state == three_wire_sio_pkg::ST_IDLE) &&
                      (clk_internal || serial_clock_pin_i); // see [R18] see [R19]
  assign start_xfer = tx_write && start_ok;

  // clearing the enable aborts a frame without a done request
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !op_enable) begin
      state <= three_wire_sio_pkg::ST_IDLE; // see [R2]
    end else if (start_xfer) begin
      state <= three_wire_sio_pkg::ST_SHIFT;
    end else if (last_rise) begin
      state <= three_wire_sio_pkg::ST_IDLE; // see [R17]
    end
  end

  // rising edges counted; the eighth one ends the frame
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || start_xfer) begin
      bit_count <= 4'h0;
    end else if (do_rise) begin
      bit_count <= bit_count + 4'h1; // see [R14]
    end
  end

  // ------------------------------------------------------------------
  // data path
  // ------------------------------------------------------------------

  // transmit register: loaded by software even when no start follows, shifted on falls
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_shift_reg <= `SHIFT_DATA_RST;
    end else if (tx_write && state == three_wire_sio_pkg::ST_IDLE) begin
      tx_shift_reg <= hwdata_i[7:0];
    end else if (do_fall) begin
      tx_shift_reg <= lsb_first ? {1'b0, tx_shift_reg[7:1]}
                                : {tx_shift_reg[6:0], 1'b0}; // see [R4] see [R15]
    end
  end

  // output latch holds its bit until the next fall, also across frames
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      serial_out_pin_o <= 1'b0;
    end else if (do_fall) begin
      serial_out_pin_o <= lsb_first ? tx_shift_reg[0] : tx_shift_reg[7]; // see [R15] see [R20]
    end
  end

  // receive shift follows the same bit order as the transmit side
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_shift_reg <= `SHIFT_DATA_RST;
    end else if (do_rise) begin
      rx_shift_reg <= lsb_first ? {serial_in_pin_i, rx_shift_reg[7:1]}
                                : {rx_shift_reg[6:0], serial_in_pin_i}; // see [R16]
    end
  end

  // buffer takes the complete byte, including the bit sampled on the last rise
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_buffer_reg <= `SHIFT_DATA_RST;
    end else if (last_rise) begin
      rx_buffer_reg <= lsb_first ? {serial_in_pin_i, rx_shift_reg[7:1]}
                                 : {rx_shift_reg[6:0], serial_in_pin_i}; // see [R21]
    end
  end

  // done request: one cycle, same edge that loads the buffer
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      transfer_done_irq_o <= 1'b0;
    end else begin
      transfer_done_irq_o <= last_rise; // see [R17] see [R21]
    end
  end

endmodule

// File: logic/three_wire_sio_defines.svh
// constants for the three-wire clocked serial block: register indexes, fields, reset values
`ifndef THREE_WIRE_SIO_DEFINES_SVH
`define THREE_WIRE_SIO_DEFINES_SVH

// register indexes; byte address is four times the index
`define ASYNC_FRAME_CONFIG_IDX   16'hff70
`define SYNC_SERIAL_MODE_IDX     16'hff72
`define BAUD_DIVIDER_SELECT_IDX  16'hff73
`define SHIFT_DATA_IDX           16'hff74
`define SERIAL_STATUS_IDX        16'hff75
`define PORT_DIRECTION_IDX       16'hff76

// reset values
`define ASYNC_FRAME_CONFIG_RST   8'h00
`define SYNC_SERIAL_MODE_RST     8'h00
`define BAUD_DIVIDER_SELECT_RST  8'h00
`define PORT_DIRECTION_RST       8'h00
`define SHIFT_DATA_RST           8'h00

// sync_serial_mode fields
`define SERIAL_OP_ENABLE_BIT     7
`define FIRST_BIT_SELECT_BIT     2
`define SERIAL_CLOCK_SOURCE_BIT  1
`define SYNC_SERIAL_MODE_MASK    8'h86

// async_frame_config fields
`define TX_ENABLE_BIT            7
`define RX_ENABLE_BIT            6
`define PARITY_SEL_HIGH_BIT      5
`define PARITY_SEL_LOW_BIT       4
`define CHAR_LENGTH_BIT          3
`define STOP_LENGTH_BIT          2
`define ASYNC_FRAME_CONFIG_MASK  8'hfc

// baud_divider_select fields
`define BAUD_DIVIDER_SELECT_MASK 8'h0f
`define SRC_CLK_SEL_MAX          4'h7

// port_direction_reg field: 1 makes the clock pin an input
`define CLOCK_PIN_INPUT_BIT      0
`define PORT_DIRECTION_MASK      8'h01

// serial status fields
`define STATUS_BUSY_BIT          0
`define STATUS_CLOCK_LEVEL_BIT   1

// transfer length in bits
`define BITS_PER_TRANSFER        4'h8

// divider counter width; half period is 2^n cycles, n at most 8
`define DIV_COUNT_W              9

// ahb encodings
`define HTRANS_NONSEQ_BIT        1
`define HRESP_OKAY               1'b0

`endif

// File: logic/three_wire_sio_pkg.sv
// types shared by the three-wire clocked serial block
package three_wire_sio_pkg;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } xfer_state_t;

endpackage
